/* File: cfgio_params.svh */
// Constants for the configurable I/O port bank: offsets, resets, masks.
// Assumes inclusion by bare name from each design file that needs them.
`ifndef CFGIO_PARAMS_SVH
`define CFGIO_PARAMS_SVH

`define CFGIO_DATA_A   8'hC0
`define CFGIO_DATA_B   8'hC1
`define CFGIO_DATA_C   8'hC3
`define CFGIO_DIR_A    8'hC4
`define CFGIO_DIR_B    8'hC5
`define CFGIO_DIR_C    8'hC6
`define CFGIO_OPT_A    8'hCC
`define CFGIO_OPT_B    8'hCD
`define CFGIO_OPT_C    8'hCF

`define CFGIO_REG_RST    8'h00
`define CFGIO_LCD_C_RST  8'hFF

`define CFGIO_ANA_A_MASK 8'hE0
`define CFGIO_ANA_B_MASK 8'h0F

`define CFGIO_SCL_BIT  5
`define CFGIO_SIN_BIT  6
`define CFGIO_SOUT_BIT 7

`define CFGIO_NUM_PORTS 3
`define CFGIO_LCD_PORT  2

`endif

/* File: cfgio_pkg.sv */
// Types shared by the configurable I/O port bank.
// Assumes nothing of its surroundings.
package cfgio_pkg;

    typedef struct packed {
        logic [7:0] drv;     // Level driven when enabled
        logic [7:0] oe_n;    // Low while the line is driven
        logic [7:0] pull_up; // Internal pull-up enable
    } cfgio_pad_t;

    typedef enum logic [1:0] {
        CFGIO_TRIG_FALL,
        CFGIO_TRIG_RISE,
        CFGIO_TRIG_LOW
    } cfgio_trig_t;

endpackage : cfgio_pkg

/* File: cfgio_sync.sv */
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous pin levels and a single core clock.
`timescale 1ns/100ps
module cfgio_sync (
    input  wire logic        ref_clk_in,  // Core clock
    input  wire logic        reset_n_in,  // Async reset, active low
    input  wire logic [23:0] raw_in,      // Raw pin levels
    output logic      [23:0] level_out    // Accepted levels
);
    logic [23:0] s1_r;
    logic [23:0] s2_r;
    logic [23:0] s3_r;

    // A change counts only once stages two and three agree.
    // Stages start high like pulled-up idle lines, so no false edge
    // reaches the interrupt detectors right after reset.
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s1_r      <= 24'hFFFFFF;
            s2_r      <= 24'hFFFFFF;
            s3_r      <= 24'hFFFFFF;
            level_out <= 24'hFFFFFF;
        end else begin
            s1_r <= raw_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < 24; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    level_out[i] <= s3_r[i];
                end
            end
        end
    end
endmodule : cfgio_sync

/* File: cfgio_irq_detect.sv */
// Per-port interrupt trigger: falling edge, rising edge or low level.
// Assumes synchronised line levels and per-line enables on one clock.
`timescale 1ns/100ps
module cfgio_irq_detect (
    input  wire logic                    ref_clk_in, // Core clock
    input  wire logic                    reset_n_in, // Async reset
    input  wire logic [7:0]              level_in,   // Synced levels
    input  wire logic [7:0]              enable_in,  // Lines in irq mode
    input  wire cfgio_pkg::cfgio_trig_t  trig_in,    // Trigger kind
    output logic                         req_out     // Request
);
    logic [7:0] prev_r;

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prev_r <= 8'hFF;
        end else begin
            prev_r <= level_in;
        end
    end

    // Edges are one-cycle requests; low level holds while low
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            req_out <= 1'b0;
        end else begin
            case (trig_in)
                cfgio_pkg::CFGIO_TRIG_FALL:
                    req_out <= |(enable_in & prev_r & ~level_in); // R12
                cfgio_pkg::CFGIO_TRIG_RISE:
                    req_out <= |(enable_in & ~prev_r & level_in); // R12
                cfgio_pkg::CFGIO_TRIG_LOW:
                    req_out <= |(enable_in & ~level_in);          // R12
                default:
                    req_out <= 1'b0;
            endcase
        end
    end
endmodule : cfgio_irq_detect

/* File: cfgio_port_bank.sv */
// Three bytewise I/O ports, each line set by data, direction, option.
// Assumes a data-space access port from the core, pad cells outside
// resolving drv/oe_n/pull_up, and LCD, converter and serial blocks.
// Function
// R1: Bit n of each port's three registers configures line n.
// R2: Data read returns sampled level of input lines.
// R3: Output lines drive the written data bit.
// R4: Input lines read the pin, writes still update the latch.
// R5: Latch bit with option bit selects the input sub-mode.
// R6: Direction 0 is input, 1 is output.
// R7: Reset clears port registers: inputs with pull-up, no interrupt. Port C data and option reset to FF instead (LCD).
// R8: Mode 000 is input with pull-up, no interrupt.
// R9: Mode 001 is input without pull-up or interrupt.
// R10: Input without pull-up leaves the pin undriven.
// R11: Mode 010 is pulled-up input routed to interrupt logic.
// R12: Per-port trigger: falling edge, rising edge or low level.
// R13: Mode 011 routes analog-capable lines to the converter mux.
// R14: Analog lines feed the 8-bit converter.
// R15: Software selects at most one analog line at a time.
// R16: Direction 1, option 0 is open-drain output.
// R17: Direction 1, option 1 is push-pull driving the latch.
// R18: Port C mode 011 is LCD segment, its reset state.
// R19: Port C LCD lines are segments 33 to 40 in order.
// R20: Software sets serial in and clock lines as inputs first.
// R21: Serial input lines stay readable through the port.
// R22: Serial out sends serial data only when open-drain.
// R23: Pin inputs pass a synchroniser on the core clock.
`timescale 1ns/100ps
`include "cfgio_params.svh"
module cfgio_port_bank (
    input  wire logic                   ref_clk_in,     // Core clock
    input  wire logic                   reset_n_in,     // Async reset
    input  wire logic [7:0]             addr_in,        // Data address
    input  wire logic                   wr_en_in,       // Write strobe
    input  wire logic [7:0]             wr_data_in,     // Write data
    input  wire logic                   rd_en_in,       // Read strobe
    output logic      [7:0]             rd_data_out,    // Read data
    input  wire logic [2:0][7:0]        pin_in,         // Pin levels
    output cfgio_pkg::cfgio_pad_t [2:0] pad_out,        // Pad controls
    output logic      [2:0][7:0]        analog_sel_out, // Converter mux
    output logic      [7:0]             lcd_mode_out,   // Port C in LCD
    input  wire logic [7:0]             lcd_segment_outputs_in, // S33+
    input  wire cfgio_pkg::cfgio_trig_t [2:0] trig_in,  // Per-port trig
    output logic      [2:0]             irq_req_out,    // Per-port irq
    input  wire logic                   serial_tx_in,   // Serial data
    output logic                        serial_input_line_out, // Sin
    output logic                        serial_clock_line_out  // Clock
);
    logic [2:0][7:0] pin_value_reg;
    logic [2:0][7:0] dir_r;
    logic [2:0][7:0] opt_r;
    logic [2:0][7:0] line_bits;
    logic [2:0][7:0] irq_en;
    cfgio_pkg::cfgio_pad_t [2:0] pad_nxt;
    logic [2:0][7:0] analog_nxt;

    // Reads mix pin levels for inputs and latches for outputs
    function automatic logic [7:0] rd_mix(input logic [7:0] lat,
                                          input logic [7:0] dir,
                                          input logic [7:0] pin);
        return (dir & lat) | (~dir & pin); // R2 R4
    endfunction : rd_mix

    function automatic logic [7:0] ana_mask(input int p);
        if (p == 0) begin
            return `CFGIO_ANA_A_MASK;
        end else if (p == 1) begin
            return `CFGIO_ANA_B_MASK;
        end
        return 8'h00;
    endfunction : ana_mask

    cfgio_sync u_sync (
        .ref_clk_in (ref_clk_in),
        .reset_n_in (reset_n_in),
        .raw_in     (pin_in),
        .level_out  (line_bits)      // R23
    );

    // Register writes; port C comes up in LCD mode
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pin_value_reg <= {`CFGIO_LCD_C_RST, `CFGIO_REG_RST,
                              `CFGIO_REG_RST};             // R7 R18
            dir_r <= {3{`CFGIO_REG_RST}};                  // R7
            opt_r <= {`CFGIO_LCD_C_RST, `CFGIO_REG_RST,
                      `CFGIO_REG_RST};                     // R7 R18
        end else if (wr_en_in) begin
            if (addr_in == `CFGIO_DATA_A) begin
                pin_value_reg[0] <= wr_data_in;            // R4
            end else if (addr_in == `CFGIO_DATA_B) begin
                pin_value_reg[1] <= wr_data_in;
            end else if (addr_in == `CFGIO_DATA_C) begin
                pin_value_reg[2] <= wr_data_in;
            end else if (addr_in == `CFGIO_DIR_A) begin
                dir_r[0] <= wr_data_in;
            end else if (addr_in == `CFGIO_DIR_B) begin
                dir_r[1] <= wr_data_in;
            end else if (addr_in == `CFGIO_DIR_C) begin
                dir_r[2] <= wr_data_in;
            end else if (addr_in == `CFGIO_OPT_A) begin
                opt_r[0] <= wr_data_in;
            end else if (addr_in == `CFGIO_OPT_B) begin
                opt_r[1] <= wr_data_in;
            end else if (addr_in == `CFGIO_OPT_C) begin
                opt_r[2] <= wr_data_in;
            end
        end
    end

    // Registered read; unmapped addresses answer zero
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_data_out <= 8'h00;
        end else if (rd_en_in) begin
            if (addr_in == `CFGIO_DATA_A) begin
                rd_data_out <= rd_mix(pin_value_reg[0], dir_r[0],
                                      line_bits[0]);
            end else if (addr_in == `CFGIO_DATA_B) begin
                rd_data_out <= rd_mix(pin_value_reg[1], dir_r[1],
                                      line_bits[1]);       // R21
            end else if (addr_in == `CFGIO_DATA_C) begin
                rd_data_out <= rd_mix(pin_value_reg[2], dir_r[2],
                                      line_bits[2]);
            end else if (addr_in == `CFGIO_DIR_A) begin
                rd_data_out <= dir_r[0];
            end else if (addr_in == `CFGIO_DIR_B) begin
                rd_data_out <= dir_r[1];
            end else if (addr_in == `CFGIO_DIR_C) begin
                rd_data_out <= dir_r[2];
            end else if (addr_in == `CFGIO_OPT_A) begin
                rd_data_out <= opt_r[0];
            end else if (addr_in == `CFGIO_OPT_B) begin
                rd_data_out <= opt_r[1];
            end else if (addr_in == `CFGIO_OPT_C) begin
                rd_data_out <= opt_r[2];
            end else begin
                rd_data_out <= 8'h00;
            end
        end
    end

    // Per-line mode decode from direction, option and latch
    always_comb begin
        for (int p = 0; p < `CFGIO_NUM_PORTS; p++) begin
            for (int b = 0; b < 8; b++) begin
                logic d;
                logic o;
                logic l;
                logic od_val;
                logic [7:0] am;
                d = dir_r[p][b];                           // R1
                o = opt_r[p][b];
                l = pin_value_reg[p][b];
                od_val = l;
                am = ana_mask(p);
                if (p == 1 && b == `CFGIO_SOUT_BIT) begin
                    od_val = l & serial_tx_in;             // R22
                end
                pad_nxt[p].drv[b]     = 1'b0;
                pad_nxt[p].oe_n[b]    = 1'b1;              // R10
                pad_nxt[p].pull_up[b] = 1'b0;              // R9
                analog_nxt[p][b]      = 1'b0;
                irq_en[p][b]          = 1'b0;
                if (d) begin                               // R6
                    if (o) begin
                        pad_nxt[p].drv[b]  = l;            // R3 R17
                        pad_nxt[p].oe_n[b] = 1'b0;
                    end else begin
                        pad_nxt[p].oe_n[b] = od_val;       // R16 R22
                    end
                end else if (!l) begin
                    pad_nxt[p].pull_up[b] = 1'b1;          // R5 R8
                    irq_en[p][b] = o;                      // R11
                end else if (o) begin
                    if (p == `CFGIO_LCD_PORT) begin
                        pad_nxt[p].drv[b] =
                            lcd_segment_outputs_in[b];     // R18 R19
                        pad_nxt[p].oe_n[b] = 1'b0;
                    end else begin
                        analog_nxt[p][b] = am[b];          // R13 R14
                    end
                end
            end
        end
    end

    // Pad controls come from flip-flops; reset leaves all lines released
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pad_out        <= {3{24'h00FF00}};
            analog_sel_out <= {3{8'h00}};
            lcd_mode_out   <= 8'h00;
        end else begin
            pad_out        <= pad_nxt;
            analog_sel_out <= analog_nxt;
            lcd_mode_out   <= ~dir_r[2] & opt_r[2] & pin_value_reg[2];
        end
    end

    // Serial block sees the same filtered levels as the port reads
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            serial_input_line_out <= 1'b0;
            serial_clock_line_out <= 1'b0;
        end else begin
            serial_input_line_out <= line_bits[1][`CFGIO_SIN_BIT]; // R21
            serial_clock_line_out <= line_bits[1][`CFGIO_SCL_BIT];
        end
    end

    for (genvar g = 0; g < `CFGIO_NUM_PORTS; g++) begin : g_irq
        cfgio_irq_detect u_irq (
            .ref_clk_in (ref_clk_in),
            .reset_n_in (reset_n_in),
            .level_in   (line_bits[g]),
            .enable_in  (irq_en[g]),
            .trig_in    (trig_in[g]),
            .req_out    (irq_req_out[g])
        );
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    a_read_input: assert property ( // R2
        rd_en_in && addr_in == `CFGIO_DATA_B && dir_r[1] == 8'h00
        |=> rd_data_out == $past(line_bits[1]))
        else $error("input read does not return pin level");

    a_read_output: assert property ( // R4
        rd_en_in && addr_in == `CFGIO_DATA_A && dir_r[0] == 8'hFF
        |=> rd_data_out == $past(pin_value_reg[0]))
        else $error("output read does not return latch");

    a_dir_write: assert property ( // R6
        wr_en_in && addr_in == `CFGIO_DIR_A
        |=> dir_r[0] == $past(wr_data_in) ##1 !pad_out[0].oe_n[0]
            == (dir_r[0][0] && (opt_r[0][0] || !pin_value_reg[0][0])))
        else $error("direction write not applied");

    a_push_pull: assert property ( // R17
        dir_r[0][5] && opt_r[0][5]
        |=> !pad_out[0].oe_n[5] && pad_out[0].drv[5]
            == $past(pin_value_reg[0][5]))
        else $error("push-pull line not driving latch");

    a_open_drain: assert property ( // R16
        dir_r[0][1] && !opt_r[0][1]
        |=> pad_out[0].oe_n[1] == $past(pin_value_reg[0][1])
            && !pad_out[0].drv[1])
        else $error("open-drain line drives wrong level");

    a_pullup_in: assert property ( // R8
        !dir_r[0][2] && !pin_value_reg[0][2]
        |=> pad_out[0].pull_up[2] && pad_out[0].oe_n[2])
        else $error("pulled-up input misconfigured");

    a_hiz_in: assert property ( // R10
        !dir_r[0][0] && !opt_r[0][0] && pin_value_reg[0][0]
        |=> pad_out[0].oe_n[0] && !pad_out[0].pull_up[0])
        else $error("input without pull-up not released");

    a_analog_sel: assert property ( // R13
        !dir_r[0][5] && opt_r[0][5] && pin_value_reg[0][5]
        |=> analog_sel_out[0][5] && pad_out[0].oe_n[5])
        else $error("analog line not routed to converter");

    a_lcd_drive: assert property ( // R18
        !dir_r[2][0] && opt_r[2][0] && pin_value_reg[2][0]
        |=> lcd_mode_out[0] && !pad_out[2].oe_n[0]
            && pad_out[2].drv[0] == $past(lcd_segment_outputs_in[0]))
        else $error("lcd line not driving segment");

    a_serial_out: assert property ( // R22
        dir_r[1][7] && !opt_r[1][7]
        |=> pad_out[1].oe_n[7]
            == $past(pin_value_reg[1][7] & serial_tx_in))
        else $error("serial data not on open-drain line");

    a_irq_gate: assert property ( // R11
        irq_req_out[0] |-> $past(|irq_en[0]))
        else $error("interrupt from a line not in irq mode");

    a_irq_gate_b: assert property ( // R11
        irq_req_out[1] |-> $past(|irq_en[1]))
        else $error("port b interrupt from a line not in irq mode");

    // Filtered levels never change on two cycles in a row
    a_irq_edge: assert property ( // R12
        irq_req_out[0] && $past(trig_in[0]) != cfgio_pkg::CFGIO_TRIG_LOW
        && trig_in[0] != cfgio_pkg::CFGIO_TRIG_LOW |=> !irq_req_out[0])
        else $error("edge request longer than one cycle");

    a_ana_capable: assert property ( // R13
        analog_sel_out[0][4:0] == 5'h00 && analog_sel_out[1][7:4] == 4'h0
        && analog_sel_out[2] == 8'h00)
        else $error("analog select on a line without converter input");

    c_irq_fire: cover property (irq_req_out[0]);
    c_lcd_seg: cover property (lcd_mode_out[3] && pad_out[2].drv[3]);
    c_od_low: cover property (dir_r[1][7] && !pad_out[1].oe_n[7]);
    c_analog: cover property (analog_sel_out[1][3]);
    c_irq_level: cover property (irq_req_out[2]);

endmodule : cfgio_port_bank

/* File: cfgio_pin_model.sv */
// Board side of the port bank: resolves pad controls into pin levels.
// Assumes registered pad controls and board drivers set by the bench.
`timescale 1ns/100ps
module cfgio_pin_model (
    input  wire logic                        ref_clk_in, // Core clock
    input  wire cfgio_pkg::cfgio_pad_t [2:0] pad_in,     // Pad controls
    input  wire logic [2:0][7:0]             ext_en_in,  // Board drives
    input  wire logic [2:0][7:0]             ext_val_in, // Board level
    output logic      [2:0][7:0]             pin_out     // Pin levels
);
    // A floating line toggles every cycle, so the sync filter never accepts it and holds the last level
    logic [7:0] float_r = 8'h55;

    always_ff @(posedge ref_clk_in) begin
        float_r <= ~float_r;
    end

    always_comb begin
        for (int p = 0; p < 3; p++) begin
            for (int b = 0; b < 8; b++) begin
                pin_out[p][b] = !pad_in[p].oe_n[b] ? pad_in[p].drv[b] :
                    ext_en_in[p][b] ? ext_val_in[p][b] :
                    pad_in[p].pull_up[b] ? 1'b1 : float_r[b];
            end
        end
    end
endmodule : cfgio_pin_model

/* File: cfgio_port_bank_tb.sv */
// Self-checking bench for the port bank through its data-space port.
// Assumes the pin model on the far side; one core clock at 250 MHz.
`timescale 1ns/100ps
`include "cfgio_params.svh"
module cfgio_port_bank_tb;
    logic                        ref_clk_in, reset_n_in, wr_en, rd_en;
    logic                        serial_tx, sin_l, scl_l;
    logic [7:0]                  addr, wr_data, rd_data, lcd_mode, seg, v;
    logic [2:0][7:0]             pins, ana, ext_en, ext_val;
    logic [2:0]                  irq;
    cfgio_pkg::cfgio_pad_t [2:0] pad;
    cfgio_pkg::cfgio_trig_t [2:0] trig;
    int                          error_cnt = 0;
    int                          num_checks = 0;
    int                          n;

    cfgio_port_bank cfgio_port_bank_i (.ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in), .addr_in(addr), .wr_en_in(wr_en),
        .wr_data_in(wr_data), .rd_en_in(rd_en), .rd_data_out(rd_data),
        .pin_in(pins), .pad_out(pad), .analog_sel_out(ana),
        .lcd_mode_out(lcd_mode), .lcd_segment_outputs_in(seg),
        .trig_in(trig), .irq_req_out(irq), .serial_tx_in(serial_tx),
        .serial_input_line_out(sin_l), .serial_clock_line_out(scl_l));

    cfgio_pin_model cfgio_pin_model_i (.ref_clk_in(ref_clk_in),
        .pad_in(pad), .ext_en_in(ext_en), .ext_val_in(ext_val),
        .pin_out(pins));

    initial begin
        ref_clk_in = 1'b0;
        forever #2 ref_clk_in = ~ref_clk_in;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic idle(input int c);
        repeat (c) @(negedge ref_clk_in);
    endtask : idle

    // One idle cycle after each access keeps strobes single-driven
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wr_data = d;
        wr_en = 1'b1;
        idle(1);
        wr_en = 1'b0;
        idle(1);
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        rd_en = 1'b1;
        idle(1);
        rd_en = 1'b0;
        v = rd_data;
        chk(v, exp);
        idle(1);
    endtask : rchk

    // Bounded wait for a request on one port
    task automatic wait_irq(input int p);
        n = 0;
        while (irq[p] !== 1'b1 && n < 12) begin
            idle(1);
            n++;
        end
    endtask : wait_irq

    task automatic test_done();
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done

    initial begin
        #200000;
        error_cnt++;
        test_done();
    end

    initial begin
        reset_n_in = 1'b0;
        {addr, wr_data, wr_en, rd_en} = '0;
        {ext_en, ext_val} = '0;
        seg = 8'h3A;
        serial_tx = 1'b1;
        trig[0] = cfgio_pkg::CFGIO_TRIG_FALL;
        trig[1] = cfgio_pkg::CFGIO_TRIG_RISE;
        trig[2] = cfgio_pkg::CFGIO_TRIG_LOW;
        idle(8);
        reset_n_in = 1'b1;
        idle(2);
        chk(pad[0].pull_up, 8'hFF);
        chk(pad[1].oe_n, 8'hFF);
        chk(lcd_mode, `CFGIO_LCD_C_RST);
        chk(pad[2].oe_n, 8'h00);
        chk(pad[2].drv, 8'h3A);
        rchk(`CFGIO_DIR_A, `CFGIO_REG_RST);
        rchk(`CFGIO_DIR_C, `CFGIO_REG_RST);
        rchk(`CFGIO_OPT_B, `CFGIO_REG_RST);
        rchk(`CFGIO_OPT_C, `CFGIO_LCD_C_RST);
        rchk(8'hC2, 8'h00);
        // Mixed byte: open-drain, push-pull, pulled-up and hi-Z inputs
        ext_en[0] = 8'h05;
        ext_val[0] = 8'h01;
        wr(`CFGIO_DATA_A, 8'hA5);
        wr(`CFGIO_OPT_A, 8'h30);
        wr(`CFGIO_DIR_A, 8'hF0);
        idle(8);
        chk(pad[0].oe_n, 8'h8F);
        chk(pad[0].drv & 8'h30, 8'h20);
        chk(pad[0].pull_up & 8'h0F, 8'h0A);
        rchk(`CFGIO_DATA_A, 8'hAB);
        ext_val[0] = 8'h04;
        rchk(`CFGIO_DATA_A, 8'hAB);
        idle(8);
        rchk(`CFGIO_DATA_A, 8'hAE);
        wr(`CFGIO_DIR_A, 8'hFF);
        rchk(`CFGIO_DATA_A, 8'hA5);
        // Analog: one line at a time, never two together
        ext_en[0] = 8'h00;
        wr(`CFGIO_DIR_A, 8'h00);
        wr(`CFGIO_OPT_A, 8'h21);
        wr(`CFGIO_DATA_A, 8'h21);
        idle(2);
        chk(ana[0], 8'h20);
        wr(`CFGIO_OPT_A, 8'h00);
        wr(`CFGIO_OPT_B, 8'h08);
        wr(`CFGIO_DATA_B, 8'h08);
        idle(2);
        chk(ana[1], 8'h08);
        chk(ana[0], 8'h00);
        // LCD exit on one combined line, segment order on the rest
        wr(`CFGIO_DIR_C, 8'h01);
        seg = 8'h1E;
        idle(2);
        chk(lcd_mode, 8'hFE);
        chk(pad[2].drv, 8'h1F);
        // Serial lines stay readable while used as inputs
        wr(`CFGIO_OPT_B, 8'h00);
        wr(`CFGIO_DATA_B, 8'h00);
        ext_en[1] = 8'h60;
        ext_val[1] = 8'h40;
        idle(8);
        chk({6'h00, sin_l, scl_l}, 8'h02);
        rchk(`CFGIO_DATA_B, 8'hDF);
        ext_val[1] = 8'h20;
        idle(8);
        chk({6'h00, sin_l, scl_l}, 8'h01);
        wr(`CFGIO_DATA_B, 8'h80);
        wr(`CFGIO_DIR_B, 8'h80);
        serial_tx = 1'b0;
        idle(2);
        chk(pad[1].oe_n & 8'h80, 8'h00);
        serial_tx = 1'b1;
        idle(2);
        chk(pad[1].oe_n & 8'h80, 8'h80);
        serial_tx = 1'b0;
        wr(`CFGIO_OPT_B, 8'h80);
        idle(2);
        chk(pad[1].oe_n & 8'h80, 8'h00);
        chk(pad[1].drv & 8'h80, 8'h80);
        // Interrupt on line A0 in every trigger kind
        wr(`CFGIO_OPT_A, 8'h01);
        wr(`CFGIO_DATA_A, 8'h00);
        ext_en[0] = 8'h01;
        for (int k = 0; k < 3; k++) begin
            trig[0] = cfgio_pkg::cfgio_trig_t'(k);
            ext_val[0][0] = (k != 1);
            idle(8);
            chk({7'h00, irq[0]}, 8'h00);
            ext_val[0][0] = (k == 1);
            wait_irq(0);
            chk({7'h00, irq[0]}, 8'h01);
        end
        wr(`CFGIO_DATA_A, 8'h01);
        idle(8);
        chk({7'h00, irq[0]}, 8'h00);
        // Ports B and C: rising edge pulses once, low level holds
        ext_en[1] = 8'h61;
        ext_en[2] = 8'h02;
        ext_val[2] = 8'h02;
        wr(`CFGIO_OPT_B, 8'h81);
        wr(`CFGIO_DATA_C, 8'hFD);
        idle(8);
        chk({6'h00, irq[2:1]}, 8'h00);
        ext_val[1][0] = 1'b1;
        ext_val[2][1] = 1'b0;
        wait_irq(1);
        chk({6'h00, irq[2:1]}, 8'h03);
        idle(1);
        chk({6'h00, irq[2:1]}, 8'h02);
        test_done();
    end
endmodule : cfgio_port_bank_tb
